/* uart_fifo_model.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_fifo_model (
  // Clock and test controls
  input  wire logic                           clock,
  input  wire logic                           load,
  input  wire logic                           drain,
  // Block strobes
  input  wire logic                           rx_pop,
  input  wire logic                           tx_push,
  // FIFO state
  output logic      [uart_irq_pkg::CNT_W-1:0] rx_count,
  output logic      [uart_irq_pkg::CNT_W-1:0] tx_count,
  output logic      [7:0]                     rx_data,
  output logic                                tx_shift_empty
);
  initial begin
    rx_count = 5'h00;
    tx_count = 5'h00;
  end

  // Counts saturate at sixteen and never wrap below empty
  always @(posedge clock) begin
    rx_count <= rx_count + 5'((load && rx_count != 5'h10)) - 5'((rx_pop && rx_count != 5'h00));
    tx_count <= tx_count + 5'((tx_push && tx_count != 5'h10)) - 5'((drain && tx_count != 5'h00));
  end

  // Head byte changes with every count so stale data is never mistaken for fresh
  assign rx_data = {3'h5, rx_count};
  assign tx_shift_empty = (tx_count == 5'h00);
endmodule : uart_fifo_model

`default_nettype wire

/* uart_irq_enable_dma_ready.sv */
// Overview of operation
// - Enabled pending sources drive interrupt pin
// - Modem delta flags raise modem interrupt
// - Line error flags raise line interrupt
// - Transmit empty raises transmit interrupt
// - Transmit empty reported at level three
// - Non-FIFO receive interrupt follows holding data
// - FIFO receive interrupt follows trigger level
// - Interrupt enables reset to zero
// - Receive status follows trigger level condition
// - Data ready set on load, clear empty
// - FIFO-mode transmit empty cleared by source read or data write
// - All enables clear means no interrupts
// - Line bits four-one show error type
// - Bit five FIFO empty, six all empty
// - Bit seven shows FIFO data error
// - Mode zero transmit ready low when empty
// - Mode zero receive ready low on data
// - Mode one transmit ready low if space
// - Mode one receive irq at trigger, fills
// - Mode one receive ready latched until empty
// - Mode zero transmit ready high after write
// - Mode one transmit ready high only full
//
`timescale 1ns/1ps
`default_nettype none

module uart_irq_enable_dma_ready
  import uart_irq_pkg::*;
#(
  parameter int DEPTH = uart_irq_pkg::FIFO_DEPTH,
  parameter int TRIG0 = uart_irq_pkg::TRIG_DEF_0,
  parameter int TRIG1 = uart_irq_pkg::TRIG_DEF_1,
  parameter int TRIG2 = uart_irq_pkg::TRIG_DEF_2,
  parameter int TRIG3 = uart_irq_pkg::TRIG_DEF_3
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           arst_n,
  // Host bus pins
  input  wire logic                           cs_n,
  input  wire logic                           read_not_write,
  input  wire logic [2:0]                     addr,
  input  wire logic [7:0]                     data_in,
  output logic      [7:0]                     data_out,
  output logic                                data_oe,
  // Receive FIFO side
  input  wire logic [uart_irq_pkg::CNT_W-1:0] rx_count,
  input  wire logic [7:0]                     rx_data,
  input  wire logic [3:0]                     rx_err_flags,
  input  wire logic                           rx_fifo_err,
  output logic                                rx_pop,
  output logic                                line_state_read,
  // Transmit FIFO side
  input  wire logic [uart_irq_pkg::CNT_W-1:0] tx_count,
  input  wire logic                           tx_shift_empty,
  output logic                                tx_push,
  output logic      [7:0]                     tx_data,
  // Modem status
  input  wire logic [3:0]                     modem_lines,
  input  wire logic [3:0]                     modem_delta,
  output logic                                modem_state_read,
  // Interrupt and DMA pins
  output logic                                irq,
  output logic                                tx_dma_request_n,
  output logic                                rx_dma_request_n
);

  import uart_irq_pkg::*;

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus pin synchronisers
  // ----------------------------------------------------------------
  logic [12:0] pins_async;
  logic [12:0] pins_sync;
  logic        cs_n_s;
  logic        rnw_s;
  logic [2:0]  addr_s;
  logic [7:0]  wdata_s;

  // Select travels active high so the flops' reset value reads as idle
  assign pins_async = {~cs_n, read_not_write, addr, data_in};

  uart_pin_sync #(
    .W        (13)
  ) u_pin_sync (
    .clock    (clock),
    .rst_n    (rst_n_q),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  assign cs_n_s  = !pins_sync[12];
  assign rnw_s   = pins_sync[11];
  assign addr_s  = pins_sync[10:8];
  assign wdata_s = pins_sync[7:0];

  // ----------------------------------------------------------------
  // Bus access tracking
  // ----------------------------------------------------------------
  bus_state_t bus_state_q;
  bus_state_t bus_state_d;
  logic       access;
  logic       rd_acc;
  logic       wr_acc;

  always_comb begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      BUS_IDLE: begin
        if (!cs_n_s) begin
          bus_state_d = BUS_ACTIVE;
        end
      end
      BUS_ACTIVE: begin
        if (cs_n_s) begin
          bus_state_d = BUS_IDLE;
        end
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_state_q <= BUS_IDLE;
    end else begin
      bus_state_q <= bus_state_d;
    end
  end

  // One access per chip-select assertion
  assign access = (bus_state_q == BUS_IDLE) && !cs_n_s;
  assign rd_acc = access && rnw_s;
  assign wr_acc = access && !rnw_s;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [3:0] ier_q;
  logic [7:0] fcr_q;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ier_q <= IER_RESET;
    end else if (wr_acc && addr_s == ADDR_IER) begin
      ier_q <= wdata_s[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fcr_q <= FCR_RESET;
    end else if (wr_acc && addr_s == ADDR_FCR) begin
      fcr_q <= {wdata_s[FCR_TRIG_HI:FCR_TRIG_LO], 2'h0,
                wdata_s[FCR_DMA], 2'h0, wdata_s[FCR_EN]};
    end
  end

  // ----------------------------------------------------------------
  // Status conditions
  // ----------------------------------------------------------------
  logic             fifo_en;
  logic             dma_mode1;
  logic [CNT_W-1:0] trig_level;
  logic             rx_at_trig;
  logic             rx_nonempty;
  logic             tx_empty;
  logic             tx_full;
  logic [7:0]       line_state_reg;

  assign fifo_en   = fcr_q[FCR_EN];
  assign dma_mode1 = fcr_q[FCR_EN] && fcr_q[FCR_DMA];

  always_comb begin
    case (fcr_q[FCR_TRIG_HI:FCR_TRIG_LO])
      2'h0:    trig_level = CNT_W'(TRIG0);
      2'h1:    trig_level = CNT_W'(TRIG1);
      2'h2:    trig_level = CNT_W'(TRIG2);
      default: trig_level = CNT_W'(TRIG3);
    endcase
  end

  assign rx_at_trig  = rx_count >= trig_level;
  assign rx_nonempty = rx_count != CNT_ZERO;
  assign tx_empty    = tx_count == CNT_ZERO;
  assign tx_full     = tx_count >= CNT_FULL;

  assign line_state_reg[0]   = rx_nonempty;
  assign line_state_reg[4:1] = rx_err_flags;
  assign line_state_reg[5]   = tx_empty;
  assign line_state_reg[6]   = tx_empty && tx_shift_empty;
  assign line_state_reg[7]   = fifo_en && rx_fifo_err;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  logic src_ls;
  logic src_rx;
  logic src_tx;
  logic src_ms;
  logic tx_empty_irq_q;
  logic tx_empty_prev_q;
  logic tx_set;
  logic tx_clr;
  logic [3:0] isr_code;

  assign src_ls = ier_q[IER_LS] && (|rx_err_flags);
  assign src_ms = ier_q[IER_MS] && (|modem_delta);
  // Level compare in FIFO mode, holding data otherwise
  assign src_rx = ier_q[IER_RX] &&
                  (fifo_en ? rx_at_trig : rx_nonempty);
  assign src_tx = ier_q[IER_TX] &&
                  (fifo_en ? tx_empty_irq_q : tx_empty);

  // Sticky empty event in FIFO mode; a new event beats a clear
  assign tx_set = tx_empty && !tx_empty_prev_q;
  assign tx_clr = (wr_acc && addr_s == ADDR_DATA) ||
                  (rd_acc && addr_s == ADDR_FCR &&
                   isr_code == ISR_TX);

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_empty_prev_q <= 1'b0;
    end else begin
      tx_empty_prev_q <= tx_empty;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_empty_irq_q <= 1'b0;
    end else if (tx_set) begin
      tx_empty_irq_q <= 1'b1;
    end else if (tx_clr) begin
      tx_empty_irq_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Priority encoding
  // ----------------------------------------------------------------
  always_comb begin
    if (src_ls) begin
      isr_code = ISR_LS;
    end else if (src_rx) begin
      isr_code = ISR_RX;
    end else if (src_tx) begin
      isr_code = ISR_TX;
    end else if (src_ms) begin
      isr_code = ISR_MS;
    end else begin
      isr_code = ISR_NONE;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq <= 1'b0;
    end else begin
      // No enable bit set means no interrupt at all
      irq <= src_ls || src_rx || src_tx || src_ms;
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    case (addr_s)
      ADDR_DATA: rd_mux = rx_data;
      ADDR_IER:  rd_mux = {4'h0, ier_q};
      ADDR_FCR:  rd_mux = {fifo_en, fifo_en, 2'h0, isr_code};
      ADDR_LSR:  rd_mux = line_state_reg;
      ADDR_MSR:  rd_mux = {modem_lines, modem_delta};
      default:   rd_mux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_out <= BYTE_ZERO;
    end else if (rd_acc) begin
      data_out <= rd_mux;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= !cs_n_s && rnw_s;
    end
  end

  // ----------------------------------------------------------------
  // Side-effect strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_pop           <= 1'b0;
      line_state_read  <= 1'b0;
      modem_state_read <= 1'b0;
      tx_push          <= 1'b0;
    end else begin
      rx_pop           <= rd_acc && addr_s == ADDR_DATA;
      line_state_read  <= rd_acc && addr_s == ADDR_LSR;
      modem_state_read <= rd_acc && addr_s == ADDR_MSR;
      tx_push          <= wr_acc && addr_s == ADDR_DATA;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_data <= BYTE_ZERO;
    end else if (wr_acc && addr_s == ADDR_DATA) begin
      tx_data <= wdata_s;
    end
  end

  // ----------------------------------------------------------------
  // DMA ready pins
  // ----------------------------------------------------------------
  logic rx_req_mode1_q;

  // Mode one receive request latches at trigger, drops when empty
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_req_mode1_q <= 1'b0;
    end else if (rx_at_trig) begin
      rx_req_mode1_q <= 1'b1;
    end else if (!rx_nonempty) begin
      rx_req_mode1_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_dma_request_n <= 1'b1;
    end else if (dma_mode1) begin
      tx_dma_request_n <= tx_full;
    end else begin
      tx_dma_request_n <= !tx_empty;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_dma_request_n <= 1'b1;
    end else if (dma_mode1) begin
      // Latch only counts while data remains, so the pin rises with empty
      rx_dma_request_n <= !((rx_req_mode1_q && rx_nonempty) || rx_at_trig);
    end else begin
      rx_dma_request_n <= !rx_nonempty;
    end
  end

endmodule : uart_irq_enable_dma_ready

`default_nettype wire

/* uart_irq_enable_dma_ready_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_irq_enable_dma_ready_tb;
  import uart_irq_pkg::*;
  logic       clock = 1'b0, arst_n = 1'b0, cs_n = 1'b1, rnw = 1'b1;
  logic       load = 1'b0, drain = 1'b0, rx_ferr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] din = 8'h00, dout, rx_data, rd;
  logic [3:0] rx_err = 4'h0, m_delta = 4'h0;
  logic [4:0] rx_count, tx_count;
  logic       oe, rx_pop, lsr_rd, tx_se, tx_push, irq, txr_n, rxr_n;
  int         n_mismatch = 0, tests_run = 0;

  always #2 clock = ~clock;

  uart_irq_enable_dma_ready i_uart_irq_enable_dma_ready (
    .clock(clock), .arst_n(arst_n), .cs_n(cs_n), .read_not_write(rnw), .addr(addr),
    .data_in(din), .data_out(dout), .data_oe(oe), .rx_count(rx_count), .rx_data(rx_data),
    .rx_err_flags(rx_err), .rx_fifo_err(rx_ferr), .rx_pop(rx_pop), .line_state_read(lsr_rd),
    .tx_count(tx_count), .tx_shift_empty(tx_se), .tx_push(tx_push), .tx_data(),
    .modem_lines(4'h0), .modem_delta(m_delta), .modem_state_read(), .irq(irq),
    .tx_dma_request_n(txr_n), .rx_dma_request_n(rxr_n));

  uart_fifo_model i_uart_fifo_model (
    .clock(clock), .load(load), .drain(drain), .rx_pop(rx_pop), .tx_push(tx_push),
    .rx_count(rx_count), .tx_count(tx_count), .rx_data(rx_data), .tx_shift_empty(tx_se));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask : tick

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Address and data settle before select; one access per select period
  task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
    rnw = r;
    addr = a;
    din = d;
    tick(3);
    cs_n = 1'b0;
    tick(6);
    rd = dout;
    cs_n = 1'b1;
    tick(5);
  endtask : acc

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    acc(1'b1, a, 8'h00);
    chk(rd, exp);
  endtask : rchk

  task automatic ichk(input logic e);
    tick(2);
    chk({7'h00, irq}, {7'h00, e});
  endtask : ichk

  task automatic pin(input logic seen, input logic e);
    chk({7'h00, seen}, {7'h00, e});
  endtask : pin

  task automatic ld(input int n);
    repeat (n) begin
      load = 1'b1;
      tick();
      load = 1'b0;
      tick();
    end
  endtask : ld

  task automatic dr(input int n);
    repeat (n) begin
      drain = 1'b1;
      tick();
      drain = 1'b0;
      tick();
    end
  endtask : dr

  task automatic pop(input int n);
    repeat (n) acc(1'b1, ADDR_DATA, 8'h00);
  endtask : pop

  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    tick(8);
    arst_n = 1'b1;
    tick(6);
    rchk(ADDR_IER, 8'h00);
    rchk(ADDR_FCR, 8'h01);
    ichk(1'b0);
    acc(1'b0, ADDR_IER, 8'h01);
    ld(1);
    ichk(1'b1);
    pin(rxr_n, 1'b0);
    pop(1);
    ichk(1'b0);
    acc(1'b0, ADDR_IER, 8'h02);
    ichk(1'b1);
    acc(1'b0, ADDR_DATA, 8'h3C);
    ichk(1'b0);
    pin(txr_n, 1'b1);
    dr(1);
    ichk(1'b1);
    pin(txr_n, 1'b0);
    acc(1'b0, ADDR_FCR, 8'h01);
    acc(1'b0, ADDR_DATA, 8'hC3);
    dr(1);
    ichk(1'b1);
    rchk(ADDR_FCR, 8'hC2);
    ichk(1'b0);
    acc(1'b0, ADDR_IER, 8'h00);
    rx_err = 4'hA;
    rx_ferr = 1'b1;
    ld(2);
    ichk(1'b0);
    rchk(ADDR_LSR, 8'hF5);
    acc(1'b0, ADDR_IER, 8'h04);
    ichk(1'b1);
    acc(1'b0, ADDR_IER, 8'h05);
    rchk(ADDR_FCR, 8'hC6);
    rx_err = 4'h0;
    rx_ferr = 1'b0;
    rchk(ADDR_FCR, 8'hC4);
    acc(1'b0, ADDR_IER, 8'h08);
    ichk(1'b0);
    m_delta = 4'h4;
    ichk(1'b1);
    rchk(ADDR_FCR, 8'hC0);
    m_delta = 4'h0;
    pop(2);
    acc(1'b0, ADDR_FCR, 8'h49);
    acc(1'b0, ADDR_IER, 8'h01);
    ld(3);
    ichk(1'b0);
    pin(rxr_n, 1'b1);
    ld(1);
    ichk(1'b1);
    pin(rxr_n, 1'b0);
    ld(12);
    rchk(ADDR_FCR, 8'hC4);
    pop(13);
    ichk(1'b0);
    pin(rxr_n, 1'b0);
    pop(3);
    pin(rxr_n, 1'b1);
    acc(1'b0, ADDR_IER, 8'h02);
    repeat (15) acc(1'b0, ADDR_DATA, 8'h5A);
    pin(txr_n, 1'b0);
    acc(1'b0, ADDR_DATA, 8'hA5);
    pin(txr_n, 1'b1);
    dr(16);
    ichk(1'b1);
    complete_run();
  end
endmodule : uart_irq_enable_dma_ready_tb

`default_nettype wire

/* uart_irq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_irq_monitor
  import uart_irq_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic                           clock,
  input wire logic                           arst_n,
  // Watched ports
  input wire logic [uart_irq_pkg::CNT_W-1:0] rx_count,
  input wire logic [uart_irq_pkg::CNT_W-1:0] tx_count,
  input wire logic                           tx_shift_empty,
  input wire logic [3:0]                     rx_err_flags,
  input wire logic                           rx_fifo_err,
  input wire logic [7:0]                     data_out,
  input wire logic                           line_state_read,
  input wire logic                           tx_dma_request_n,
  input wire logic                           rx_dma_request_n
);
  logic [2:0] up_q;
  logic       up;

  // Internal reset and pin sync lag the pin release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  assign up = (up_q == 3'h7);

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence lsr_read_s;
    up && line_state_read;
  endsequence

  rx_idle_high_a: assert property (up && $past(rx_count) == 5'h00 |-> rx_dma_request_n)
    else $error("rx ready low with empty fifo");
  rx_full_low_a: assert property (up && int'($past(rx_count)) == DEPTH |-> !rx_dma_request_n)
    else $error("rx ready high with full fifo");
  tx_empty_low_a: assert property (up && $past(tx_count) == 5'h00 |-> !tx_dma_request_n)
    else $error("tx ready high with empty fifo");
  tx_full_high_a: assert property (up && int'($past(tx_count)) == DEPTH |-> tx_dma_request_n)
    else $error("tx ready low with full fifo");
  lsr_ready_a: assert property (lsr_read_s |-> data_out[0] == ($past(rx_count) != 5'h00))
    else $error("data ready bit wrong");
  lsr_errors_a: assert property (lsr_read_s |-> data_out[4:1] == $past(rx_err_flags))
    else $error("error bits wrong");
  lsr_tx_empty_a: assert property (lsr_read_s |-> data_out[5] == ($past(tx_count) == 5'h00)
    && data_out[6] == ($past(tx_count) == 5'h00 && $past(tx_shift_empty)))
    else $error("transmit empty bits wrong");
  lsr_data_err_a: assert property (lsr_read_s |-> data_out[7] == $past(rx_fifo_err))
    else $error("fifo data error bit wrong");
endmodule : uart_irq_monitor

bind uart_irq_enable_dma_ready uart_irq_monitor #(.DEPTH(DEPTH)) i_uart_irq_monitor (
  .clock(clock), .arst_n(arst_n), .rx_count(rx_count), .tx_count(tx_count),
  .tx_shift_empty(tx_shift_empty), .rx_err_flags(rx_err_flags), .rx_fifo_err(rx_fifo_err),
  .data_out(data_out), .line_state_read(line_state_read),
  .tx_dma_request_n(tx_dma_request_n), .rx_dma_request_n(rx_dma_request_n));

`default_nettype wire

/* uart_irq_pkg.sv */
package uart_irq_pkg;

  // ----------------------------------------------------------------
  // Register addresses (A2..A0)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_IER    = 3'h1;
  localparam logic [2:0] ADDR_FCR    = 3'h2;
  localparam logic [2:0] ADDR_LSR    = 3'h5;
  localparam logic [2:0] ADDR_MSR    = 3'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IER_RX      = 0;
  localparam int IER_TX      = 1;
  localparam int IER_LS      = 2;
  localparam int IER_MS      = 3;
  localparam int FCR_EN      = 0;
  localparam int FCR_DMA     = 3;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_TRIG_HI = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [7:0] ISR_RESET = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Interrupt source codes, INTERRUPT_SOURCE_REG bits 3:0
  // ----------------------------------------------------------------
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_LS   = 4'h6;
  localparam logic [3:0] ISR_RX   = 4'h4;
  localparam logic [3:0] ISR_TX   = 4'h2;
  localparam logic [3:0] ISR_MS   = 4'h0;

  // ----------------------------------------------------------------
  // FIFO size and default trigger levels
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH   = 16;
  localparam int CNT_W        = 5;
  localparam int TRIG_DEF_0   = 1;
  localparam int TRIG_DEF_1   = 4;
  localparam int TRIG_DEF_2   = 8;
  localparam int TRIG_DEF_3   = 14;

  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ACTIVE = 1'b1
  } bus_state_t;

endpackage : uart_irq_pkg

/* uart_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module uart_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : uart_pin_sync

`default_nettype wire
